// file: uar_pkg.sv
// constants, types and register map of the asynchronous receive path
package uar_pkg;

   // register offsets, byte addresses as printed
   localparam logic [7:0] UAR_ADDR_FLAGS = 8'h0c;
   localparam logic [7:0] UAR_ADDR_RCSTAT = 8'h18;
   localparam logic [7:0] UAR_ADDR_TXDATA = 8'h19;
   localparam logic [7:0] UAR_ADDR_RXDATA = 8'h1a;
   localparam logic [7:0] UAR_ADDR_ENABLES = 8'h8c;
   localparam logic [7:0] UAR_ADDR_TXSTAT = 8'h98;
   localparam logic [7:0] UAR_ADDR_BAUD = 8'h99;
   localparam logic [7:0] UAR_ADDR_EVT_STAT = 8'h1b;
   localparam logic [7:0] UAR_ADDR_EVT_CLR = 8'h1c;
   localparam logic [7:0] UAR_ADDR_EVT_EN = 8'h1d;

   // peripheral flag / enable bit
   localparam int UAR_FLAG_RX = 5;
   localparam int UAR_EN_RX = 5;

   // receive status/control fields
   localparam int UAR_RC_SERIAL_PORT_ENABLE = 7;
   localparam int UAR_RC_RX9 = 6;
   localparam int UAR_RC_SINGLE_RECEIVE_ENABLE = 5;
   localparam int UAR_RC_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int UAR_RC_FRAMING_ERROR = 2;
   localparam int UAR_RC_OVERRUN_ERROR = 1;
   localparam int UAR_RC_RECEIVED_NINTH_BIT = 0;

   // transmit status/control fields
   localparam int UAR_TS_CLOCK_SOURCE_SELECT = 7;
   localparam int UAR_TS_TX9 = 6;
   localparam int UAR_TS_TRANSMIT_ENABLE = 5;
   localparam int UAR_TS_SYNC = 4;
   localparam int UAR_TS_HIGH_BAUD_SELECT = 2;
   localparam int UAR_TS_SHIFT_REGISTER_EMPTY = 1;
   localparam int UAR_TS_TRANSMIT_NINTH_BIT = 0;

   // reset values and writable masks
   localparam logic [7:0] UAR_RST_BYTE = 8'h00;
   localparam logic [3:0] UAR_RC_CTL_RST = 4'h0;
   localparam logic [7:0] UAR_TXSTAT_RST = 8'h02;
   localparam logic [7:0] UAR_TXSTAT_WMASK = 8'hf5;

   // event status bits
   localparam int UAR_EV_WORD = 0;
   localparam int UAR_EV_OVR = 1;
   localparam int UAR_EV_FRM = 2;
   localparam int UAR_EVT_W = 3;
   localparam logic [UAR_EVT_W-1:0] UAR_EVT_RST = 3'h0;

   // oversampling: votes on the 7th, 8th and 9th tick of sixteen
   localparam logic [3:0] UAR_SMP_FIRST = 4'h0;
   localparam logic [3:0] UAR_SMP_STEP = 4'h1;
   localparam logic [3:0] UAR_VOTE_A = 4'h6;
   localparam logic [3:0] UAR_VOTE_B = 4'h7;
   localparam logic [3:0] UAR_VOTE_C = 4'h8;
   localparam int UAR_LO_PRESCALE = 4;

   // frame sizes
   localparam logic [3:0] UAR_BIT_FIRST = 4'h0;
   localparam logic [3:0] UAR_BIT_STEP = 4'h1;
   localparam logic [3:0] UAR_LAST_BIT8 = 4'h7;
   localparam logic [3:0] UAR_LAST_BIT9 = 4'h8;
   localparam int UAR_FIFO_DEPTH = 2;

   typedef enum logic [2:0] {
      UAR_IDLE = 3'b000,
      UAR_START = 3'b001,
      UAR_DATA = 3'b011,
      UAR_STOP = 3'b010,
      UAR_SYNC_RX = 3'b110
   } uar_state_t;

   typedef struct packed {
      logic framing_error;
      logic bit9;
      logic [7:0] data;
   } uar_entry_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } uar_bus_t;

endpackage

// file: uar_rx_fifo.sv
// small receive fifo with registered head entry
module uar_rx_fifo import uar_pkg::*; #(
   parameter int DEPTH = UAR_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cen,
   input wire logic push,
   input uar_entry_t wdata,
   input wire logic pop,
   output uar_entry_t head_r,
   output logic full_r,
   output logic empty_r
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_CNT = CW'(1);

   uar_entry_t mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW-1:0] rp_inc;
   logic [AW-1:0] wp_inc;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic do_push;
   logic do_pop;

   assign do_pop = pop && !empty_r;
   assign do_push = push && !full_r;
   assign rp_inc = (rp_r == LAST_PTR) ? '0 : rp_r + 1'b1;
   assign wp_inc = (wp_r == LAST_PTR) ? '0 : wp_r + 1'b1;

   always_comb begin
      cnt_nxt = cnt_r;
      if (do_push && !do_pop) begin
         cnt_nxt = cnt_r + ONE_CNT;
      end else if (do_pop && !do_push) begin
         cnt_nxt = cnt_r - ONE_CNT;
      end
   end

   // storage needs no reset, only the head register is visible
   always_ff @(posedge clk) begin
      if (cen && do_push) begin
         mem[wp_r] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         full_r <= 1'b0;
         empty_r <= 1'b1;
      end else if (cen) begin
         if (do_push) begin
            wp_r <= wp_inc;
         end
         if (do_pop) begin
            rp_r <= rp_inc;
         end
         cnt_r <= cnt_nxt;
         full_r <= (cnt_nxt == FULL_CNT);
         empty_r <= (cnt_nxt == '0);
      end
   end

   // head is computed ahead so status reads never lag a pop
   always_ff @(posedge clk) begin
      if (rst) begin
         head_r <= '0;
      end else if (cen) begin
         if (do_push && (cnt_r == '0 || (cnt_r == ONE_CNT && do_pop))) begin
            head_r <= wdata;
         end else if (do_pop) begin
            head_r <= mem[rp_inc];
         end
      end
   end

endmodule // uar_rx_fifo

// file: uar_async_receiver.sv
// receive path of the serial port with its registers and mode select
// What this block does
// - recover bits from a sixteen-times oversampled line, shifter steps once per bit
// - asynchronous reception runs only while continuous receive enable is set
// - after the stop bit, move the word into the fifo if room; then set receive flag
// - interrupt on receive when receive flag and its enable are both set, or when any of the word, overrun and framing events and its event enable are both set
// - receive flag is read-only and clears once reading empties the fifo
// - receive data is a two-entry fifo while a third word shifts in
// - stop bit of a word with the fifo full sets overrun and drops the word
// - overrun clears only when software drops and re-sets continuous receive
// - while overrun is set no word enters the fifo
// - a low stop bit sets the framing error of that word
// - framing error and ninth bit travel per entry and advance on a data read
// - synchronous master mode is half duplex between receive and transmit
// - synchronous select plus port enable turn the pins into clock and data lines
// - with clock source select set the block drives the clock line
// - each asynchronous bit is a majority of samples at ticks seven, eight and nine; synchronous bits are single samples
// - frame is start, eight or nine data bits lsb first, one stop, no parity
//
// The address-and-strobe port was decided locally.
module uar_async_receiver import uar_pkg::*; #(
   parameter int LO_PRESCALE = UAR_LO_PRESCALE,
   parameter int FIFO_DEPTH = UAR_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cen,
   input uar_bus_t bus,
   output logic [7:0] rd_data_r,
   input wire logic serial_data_line_in,
   input wire logic tx_shift_empty,
   input wire logic tx_busy,
   output logic serial_clock_line_r,
   output logic serial_clock_line_oe_r,
   output logic [7:0] transmit_data_r,
   output logic transmit_load_r,
   output logic tx_inhibit_r,
   output logic irq_r
);
   localparam logic [7:0] PRE_LIM_LO = 8'(LO_PRESCALE - 1);

   logic [7:4] rc_ctl_r;
   logic [7:0] ts_ctl_r;
   logic [7:0] baud_r;
   logic [7:0] enables_r;
   logic [UAR_EVT_W-1:0] evt_r;
   logic [UAR_EVT_W-1:0] evt_en_r;
   logic [UAR_EVT_W-1:0] evt_set;
   logic [UAR_EVT_W-1:0] evt_clr;
   logic overrun_error_r;
   logic rx_m_r;
   logic rx_s_r;
   logic rx_d_r;
   logic [7:0] pre_r;
   logic [7:0] div_r;
   logic [7:0] pre_lim;
   logic tick;
   logic brg_run;
   logic v_a_r;
   logic v_b_r;
   logic vote;
   uar_state_t st_r;
   uar_state_t st_nxt;
   logic [3:0] smp_r;
   logic [3:0] smp_nxt;
   logic [3:0] bit_r;
   logic [3:0] bit_nxt;
   logic [3:0] last_bit;
   logic [8:0] sh_r;
   logic [8:0] sh_nxt;
   logic sclk_nxt;
   logic done;
   logic frame_err;
   logic single_receive_enable_clr;
   logic fifo_push;
   logic fifo_pop;
   logic fifo_full;
   logic fifo_empty;
   logic receive_flag;
   logic ovr_set;
   uar_entry_t entry;
   uar_entry_t head;
   logic [7:0] rd_nxt;
   logic serial_port_enable;
   logic rx9;
   logic single_receive_enable;
   logic continuous_receive_enable;
   logic clock_source_select;
   logic transmit_enable;
   logic sync;
   logic async_on;
   logic sync_rx_en;
   logic wr_hit_rc;
   logic rd_pop;

   assign serial_port_enable = rc_ctl_r[UAR_RC_SERIAL_PORT_ENABLE];
   assign rx9 = rc_ctl_r[UAR_RC_RX9];
   assign single_receive_enable = rc_ctl_r[UAR_RC_SINGLE_RECEIVE_ENABLE];
   assign continuous_receive_enable = rc_ctl_r[UAR_RC_CONTINUOUS_RECEIVE_ENABLE];
   assign clock_source_select = ts_ctl_r[UAR_TS_CLOCK_SOURCE_SELECT];
   assign transmit_enable = ts_ctl_r[UAR_TS_TRANSMIT_ENABLE];
   assign sync = ts_ctl_r[UAR_TS_SYNC];
   assign async_on = serial_port_enable && continuous_receive_enable && !sync;
   assign sync_rx_en = serial_port_enable && sync && clock_source_select && (continuous_receive_enable || single_receive_enable);
   assign last_bit = rx9 ? UAR_LAST_BIT9 : UAR_LAST_BIT8;
   assign wr_hit_rc = bus.wr && bus.addr == UAR_ADDR_RCSTAT;
   assign rd_pop = bus.rd && bus.addr == UAR_ADDR_RXDATA;
   assign receive_flag = !fifo_empty;

   // line synchroniser, idle high
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_m_r <= 1'b1;
         rx_s_r <= 1'b1;
         rx_d_r <= 1'b1;
      end else if (cen) begin
         rx_m_r <= serial_data_line_in;
         rx_s_r <= rx_m_r;
         rx_d_r <= rx_s_r;
      end
   end

   // baud generator idle while nothing is enabled; >= so a lowered limit never strands it
   assign brg_run = serial_port_enable && (continuous_receive_enable || single_receive_enable || transmit_enable);
   assign pre_lim = ts_ctl_r[UAR_TS_HIGH_BAUD_SELECT] ? UAR_RST_BYTE : PRE_LIM_LO;
   assign tick = brg_run && pre_r >= pre_lim && div_r >= baud_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_r <= UAR_RST_BYTE;
         div_r <= UAR_RST_BYTE;
      end else if (cen) begin
         if (!brg_run) begin
            pre_r <= UAR_RST_BYTE;
            div_r <= UAR_RST_BYTE;
         end else if (pre_r >= pre_lim) begin
            pre_r <= UAR_RST_BYTE;
            div_r <= (div_r >= baud_r) ? UAR_RST_BYTE : div_r + 8'h01;
         end else begin
            pre_r <= pre_r + 8'h01;
         end
      end
   end

   // majority of three samples filters glitches near the bit centre
   always_ff @(posedge clk) begin
      if (rst) begin
         v_a_r <= 1'b1;
         v_b_r <= 1'b1;
      end else if (cen && tick) begin
         if (smp_r == UAR_VOTE_A) begin
            v_a_r <= rx_s_r;
         end
         if (smp_r == UAR_VOTE_B) begin
            v_b_r <= rx_s_r;
         end
      end
   end
   assign vote = (v_a_r && v_b_r) || (v_a_r && rx_s_r) || (v_b_r && rx_s_r);

   always_comb begin
      st_nxt = st_r;
      smp_nxt = smp_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      sclk_nxt = serial_clock_line_r;
      done = 1'b0;
      frame_err = 1'b0;
      single_receive_enable_clr = 1'b0;
      if (tick && st_r != UAR_IDLE && st_r != UAR_SYNC_RX) begin
         smp_nxt = smp_r + UAR_SMP_STEP;
      end
      case (st_r)
         UAR_IDLE: begin
            sclk_nxt = 1'b0;
            if (async_on && rx_d_r && !rx_s_r) begin
               st_nxt = UAR_START;
               smp_nxt = UAR_SMP_FIRST;
            end else if (sync_rx_en && !tx_busy) begin
               st_nxt = UAR_SYNC_RX;
               bit_nxt = UAR_BIT_FIRST;
            end
         end
         UAR_START: begin
            if (tick && smp_r == UAR_VOTE_C) begin
               // a high vote means a glitch, not a start bit
               st_nxt = vote ? UAR_IDLE : UAR_DATA;
               bit_nxt = UAR_BIT_FIRST;
            end
         end
         UAR_DATA: begin
            if (tick && smp_r == UAR_VOTE_C) begin
               sh_nxt = {vote, sh_r[8:1]};
               bit_nxt = bit_r + UAR_BIT_STEP;
               if (bit_r == last_bit) begin
                  st_nxt = UAR_STOP;
               end
            end
         end
         UAR_STOP: begin
            if (tick && smp_r == UAR_VOTE_C) begin
               // back to idle mid stop bit so the next start edge is seen
               done = 1'b1;
               frame_err = !vote;
               st_nxt = UAR_IDLE;
            end
         end
         UAR_SYNC_RX: begin
            if (tick) begin
               sclk_nxt = !serial_clock_line_r;
               if (!serial_clock_line_r) begin
                  sh_nxt = {rx_s_r, sh_r[8:1]};
                  bit_nxt = bit_r + UAR_BIT_STEP;
                  if (bit_r == last_bit) begin
                     done = 1'b1;
                     single_receive_enable_clr = single_receive_enable;
                     st_nxt = UAR_IDLE;
                  end
               end
            end
         end
         default: begin
            st_nxt = UAR_IDLE;
         end
      endcase
      // dropping the enables resets the receive logic
      if ((st_r == UAR_SYNC_RX && !sync_rx_en) ||
          (st_r != UAR_IDLE && st_r != UAR_SYNC_RX && !async_on)) begin
         st_nxt = UAR_IDLE;
         done = 1'b0;
         frame_err = 1'b0;
         single_receive_enable_clr = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= UAR_IDLE;
         smp_r <= UAR_SMP_FIRST;
         bit_r <= UAR_BIT_FIRST;
         sh_r <= '0;
         serial_clock_line_r <= 1'b0;
      end else if (cen) begin
         st_r <= st_nxt;
         smp_r <= smp_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         serial_clock_line_r <= sclk_nxt;
      end
   end

   // word into the fifo, ninth bit and framing error ride along
   assign entry.data = rx9 ? sh_nxt[7:0] : sh_nxt[8:1];
   assign entry.bit9 = rx9 && sh_nxt[8];
   assign entry.framing_error = frame_err;
   assign fifo_push = done && !overrun_error_r && !fifo_full;
   assign ovr_set = done && fifo_full;
   assign fifo_pop = rd_pop;

   uar_rx_fifo #(
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .cen(cen),
      .push(fifo_push),
      .wdata(entry),
      .pop(fifo_pop),
      .head_r(head),
      .full_r(fifo_full),
      .empty_r(fifo_empty)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         overrun_error_r <= 1'b0;
      end else if (cen) begin
         if (!continuous_receive_enable) begin
            overrun_error_r <= 1'b0;
         end else if (ovr_set) begin
            overrun_error_r <= 1'b1;
         end
      end
   end

   // control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         rc_ctl_r <= UAR_RC_CTL_RST;
         ts_ctl_r <= UAR_TXSTAT_RST & UAR_TXSTAT_WMASK;
         baud_r <= UAR_RST_BYTE;
         enables_r <= UAR_RST_BYTE;
         evt_en_r <= UAR_EVT_RST;
         transmit_data_r <= UAR_RST_BYTE;
         transmit_load_r <= 1'b0;
      end else if (cen) begin
         transmit_load_r <= 1'b0;
         if (wr_hit_rc) begin
            rc_ctl_r <= bus.wdata[7:4];
         end else if (single_receive_enable_clr) begin
            rc_ctl_r[UAR_RC_SINGLE_RECEIVE_ENABLE] <= 1'b0;
         end
         if (bus.wr) begin
            case (bus.addr)
               UAR_ADDR_TXSTAT: ts_ctl_r <= bus.wdata & UAR_TXSTAT_WMASK;
               UAR_ADDR_BAUD: baud_r <= bus.wdata;
               UAR_ADDR_ENABLES: enables_r <= bus.wdata;
               UAR_ADDR_EVT_EN: evt_en_r <= bus.wdata[UAR_EVT_W-1:0];
               UAR_ADDR_TXDATA: begin
                  transmit_data_r <= bus.wdata;
                  transmit_load_r <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // sticky events: a set in the clearing cycle survives
   assign evt_set[UAR_EV_WORD] = fifo_push;
   assign evt_set[UAR_EV_OVR] = ovr_set;
   assign evt_set[UAR_EV_FRM] = done && frame_err;
   assign evt_clr = (bus.wr && bus.addr == UAR_ADDR_EVT_CLR) ?
                    bus.wdata[UAR_EVT_W-1:0] : UAR_EVT_RST;

   always_ff @(posedge clk) begin
      if (rst) begin
         evt_r <= UAR_EVT_RST;
      end else if (cen) begin
         evt_r <= (evt_r & ~evt_clr) | evt_set;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_r <= 1'b0;
         serial_clock_line_oe_r <= 1'b0;
         tx_inhibit_r <= 1'b0;
      end else if (cen) begin
         irq_r <= (enables_r[UAR_EN_RX] && receive_flag) || |(evt_r & evt_en_r);
         serial_clock_line_oe_r <= serial_port_enable && sync && clock_source_select;
         tx_inhibit_r <= serial_port_enable && sync && (continuous_receive_enable || single_receive_enable);
      end
   end

   // read mux, data valid only in the cycle after the strobe
   always_comb begin
      rd_nxt = UAR_RST_BYTE;
      case (bus.addr)
         UAR_ADDR_FLAGS: rd_nxt[UAR_FLAG_RX] = receive_flag;
         UAR_ADDR_RCSTAT: begin
            rd_nxt[7:4] = rc_ctl_r;
            rd_nxt[UAR_RC_FRAMING_ERROR] = head.framing_error;
            rd_nxt[UAR_RC_OVERRUN_ERROR] = overrun_error_r;
            rd_nxt[UAR_RC_RECEIVED_NINTH_BIT] = head.bit9;
         end
         UAR_ADDR_TXDATA: rd_nxt = transmit_data_r;
         UAR_ADDR_RXDATA: rd_nxt = head.data;
         UAR_ADDR_ENABLES: rd_nxt = enables_r;
         UAR_ADDR_TXSTAT: begin
            rd_nxt = ts_ctl_r;
            rd_nxt[UAR_TS_SHIFT_REGISTER_EMPTY] = tx_shift_empty;
         end
         UAR_ADDR_BAUD: rd_nxt = baud_r;
         UAR_ADDR_EVT_STAT: rd_nxt[UAR_EVT_W-1:0] = evt_r;
         UAR_ADDR_EVT_EN: rd_nxt[UAR_EVT_W-1:0] = evt_en_r;
         default: rd_nxt = UAR_RST_BYTE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_r <= UAR_RST_BYTE;
      end else if (cen) begin
         rd_data_r <= bus.rd ? rd_nxt : UAR_RST_BYTE;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_start_edge;
      cen && st_r == UAR_IDLE && async_on && rx_d_r && !rx_s_r;
   endsequence
   sequence s_last_read;
      cen && rd_pop && !fifo_full && !fifo_empty && !fifo_push;
   endsequence

   chk_start_edge: assert property (s_start_edge |=> st_r == UAR_START)
      else $error("falling edge did not start a frame");
   chk_rx_enable: assert property (st_r == UAR_IDLE ##1 st_r == UAR_START |->
      $past(async_on))
      else $error("frame started while reception disabled");
   chk_push_flag: assert property (cen && fifo_push |=> receive_flag)
      else $error("receive flag not set after push");
   chk_irq_source: assert property (cen && enables_r[UAR_EN_RX] && receive_flag |=> irq_r)
      else $error("receive interrupt missing");
   chk_irq_masked: assert property (irq_r |-> $past(enables_r[UAR_EN_RX] && receive_flag) ||
      $past(|(evt_r & evt_en_r)))
      else $error("interrupt without enabled cause");
   chk_flag_clear: assert property (s_last_read |=> !receive_flag)
      else $error("receive flag stayed after last read");
   chk_ovr_set: assert property (cen && done && fifo_full && continuous_receive_enable |=> overrun_error_r)
      else $error("overrun not flagged");
   chk_ovr_sticky: assert property (cen && overrun_error_r && continuous_receive_enable |=> overrun_error_r)
      else $error("overrun cleared without receive reset");
   chk_ovr_clear: assert property (cen && !continuous_receive_enable |=> !overrun_error_r)
      else $error("overrun survived receive reset");
   chk_ovr_blocks: assert property (overrun_error_r |-> !fifo_push)
      else $error("push while overrun set");
   chk_framing_error_stop: assert property (st_r == UAR_STOP && fifo_push |-> entry.framing_error == !vote)
      else $error("framing error does not follow stop bit");
   chk_half_duplex: assert property (cen && st_r == UAR_IDLE && sync_rx_en && tx_busy
      |=> st_r != UAR_SYNC_RX)
      else $error("sync receive started during transmit");
   chk_clock_drive: assert property (cen && serial_port_enable && sync && clock_source_select |=> serial_clock_line_oe_r)
      else $error("clock line not driven in master mode");

endmodule // uar_async_receiver

// file: uar_line_model.sv
// remote serial transmitter driving the receive line
module uar_line_model #(
   parameter int BIT_CLK = 16,
   parameter int LO_MUL = 4
) (
   input wire logic clk,
   input wire logic go,
   input wire logic slow,
   input wire logic [8:0] word,
   input wire logic [3:0] nbits,
   input wire logic stop_v,
   output logic line_r,
   output logic busy_r
);
   timeunit 1ns;
   timeprecision 1ns;
   int i;
   int n;
   initial begin
      line_r = 1'b1;
      busy_r = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            // slow stretches every bit for the low-speed setting
            n = slow ? LO_MUL * BIT_CLK : BIT_CLK;
            busy_r <= 1'b1;
            line_r <= 1'b0;
            repeat (n) @(posedge clk);
            for (i = 0; i < nbits; i++) begin
               line_r <= word[i];
               repeat (n) @(posedge clk);
            end
            // stop driven low only when a test asks for a bad frame
            line_r <= stop_v;
            repeat (n) @(posedge clk);
            line_r <= 1'b1;
            busy_r <= 1'b0;
         end
      end
   end
endmodule // uar_line_model

// file: usart_async_receiver_tb.sv
// self-checking bench for the asynchronous receive path
module usart_async_receiver_tb import uar_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, cen = 1, tx_empty = 1, tx_busy = 0;
   logic go = 0, stop_v = 1, ovr = 0, slow = 0;
   logic [8:0] word = '0;
   logic [3:0] nbits = 4'h8;
   uar_bus_t bus = '0;
   logic [7:0] rd_data_r, v, ctl = 8'h00;
   logic line, m_busy, sclk, sclk_oe, tload, tinh, irq;
   logic [7:0] tdata;
   logic [7:0] ra [9] = '{8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h55, 8'h1b};
   int n_fail = 0, num_checks = 0, seed = 46559, q[$];

   always #10 clk = ~clk;

   uar_async_receiver i_dut (.clk(clk), .rst(rst), .cen(cen), .bus(bus),
      .rd_data_r(rd_data_r), .serial_data_line_in(line), .tx_shift_empty(tx_empty),
      .tx_busy(tx_busy), .serial_clock_line_r(sclk), .serial_clock_line_oe_r(sclk_oe),
      .transmit_data_r(tdata), .transmit_load_r(tload), .tx_inhibit_r(tinh), .irq_r(irq));

   // one bit time is 16 clocks with divisor 0 and high baud select
   uar_line_model i_far (.clk(clk), .go(go), .slow(slow), .word(word), .nbits(nbits),
      .stop_v(stop_v), .line_r(line), .busy_r(m_busy));

   task test_done;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
   endtask

   task chb(input logic s, input logic e);
      chk({7'h0, s}, {7'h0, e});
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) bus <= {a, d, 2'b10};
      @(posedge clk) bus.wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk) bus <= {a, 8'h00, 2'b01};
      @(posedge clk) bus.rd <= 1'b0;
      #1 d = rd_data_r;
   endtask

   task wctl(input logic [7:0] d);
      ctl = d;
      if (!d[4])
         ovr = 1'b0;
      wr(UAR_ADDR_RCSTAT, d);
   endtask

   // sends one frame, then updates the reference fifo
   task send(input logic [8:0] w, input logic sv);
      @(posedge clk);
      word <= w;
      stop_v <= sv;
      nbits <= ctl[6] ? 4'h9 : 4'h8;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      repeat (800) if (m_busy) @(posedge clk);
      repeat (4) @(posedge clk);
      if (ctl[4]) begin
         if (!ovr && q.size() < 2)
            q.push_back({22'h0, !sv, ctl[6] & w[8], w[7:0]});
         else
            ovr = 1'b1;
      end
   endtask

   // status first, then data, since the head's flags move on a data read
   task pop_chk;
      int e;
      e = q.pop_front();
      rd(UAR_ADDR_RCSTAT, v);
      chk(v & {7'h7f, ctl[6]}, {ctl[7:4], 1'b0, e[9], ovr, e[8]});
      rd(UAR_ADDR_RXDATA, v);
      chk(v, e[7:0]);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done;
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd(ra[i], v);
         chk(v, i == 5 ? 8'h02 : 8'h00);
      end
      wr(UAR_ADDR_TXDATA, 8'ha5);
      #1 chb(tload, 1'b1);
      chk(tdata, 8'ha5);
      rd(UAR_ADDR_TXDATA, v);
      chk(v, 8'ha5);
      chb(tload, 1'b0);
      wr(UAR_ADDR_BAUD, 8'h00);
      wr(UAR_ADDR_TXSTAT, 8'h04);
      wctl(8'h80);
      wr(UAR_ADDR_ENABLES, 8'h20);
      send(9'($random(seed)), 1'b1);
      rd(UAR_ADDR_FLAGS, v);
      chk(v, 8'h00);
      wctl(8'h90);
      send(9'($random(seed)), 1'b1);
      chb(irq, 1'b1);
      rd(UAR_ADDR_FLAGS, v);
      chk(v, 8'h20);
      rd(UAR_ADDR_EVT_STAT, v);
      chk(v, 8'h01);
      wr(UAR_ADDR_EVT_CLR, 8'h07);
      rd(UAR_ADDR_EVT_STAT, v);
      chk(v, 8'h00);
      pop_chk;
      rd(UAR_ADDR_FLAGS, v);
      chk(v, 8'h00);
      chb(irq, 1'b0);
      // overrun: four words with nobody reading
      wr(UAR_ADDR_ENABLES, 8'h00);
      wr(UAR_ADDR_EVT_EN, 8'h02);
      send(9'($random(seed)), 1'b1);
      chb(irq, 1'b0);
      repeat (3) send(9'($random(seed)), 1'b1);
      chb(irq, 1'b1);
      pop_chk;
      pop_chk;
      rd(UAR_ADDR_FLAGS, v);
      chk(v, 8'h00);
      wctl(8'h80);
      wctl(8'h90);
      wr(UAR_ADDR_EVT_CLR, 8'h02);
      @(posedge clk);
      #1 chb(irq, 1'b0);
      send(9'($random(seed)), 1'b1);
      pop_chk;
      // low-speed setting: four clocks per tick, 64 clocks per bit
      wr(UAR_ADDR_TXSTAT, 8'h00);
      @(posedge clk) slow <= 1'b1;
      send(9'($random(seed)), 1'b1);
      pop_chk;
      wr(UAR_ADDR_TXSTAT, 8'h04);
      @(posedge clk) slow <= 1'b0;
      // nine-bit words, alternating bad stop bits, two queued per pass
      wctl(8'hd0);
      repeat (2) begin
         send(9'($random(seed)), 1'b0);
         send(9'($random(seed)), 1'b1);
         pop_chk;
         pop_chk;
      end
      // synchronous master pin assignment and half duplex
      wr(UAR_ADDR_TXSTAT, 8'h94);
      wctl(8'h80);
      @(posedge clk);
      #1 chb(sclk_oe, 1'b1);
      chb(tinh, 1'b0);
      @(posedge clk) tx_busy <= 1'b1;
      wctl(8'h90);
      repeat (2) @(posedge clk);
      #1 chb(tinh, 1'b1);
      chb(sclk, 1'b0);
      @(posedge clk) tx_busy <= 1'b0;
      repeat (3) @(posedge clk);
      #1 v[0] = sclk;
      @(posedge clk);
      #1 chb(sclk, !v[0]);
      test_done;
   end
endmodule // usart_async_receiver_tb
